// [design/psm_clk_div.v]
// programmable clock-enable divider for core and peripheral clocks
`timescale 1ns/1ps
`include "psm_defs.vh"
module psm_clk_div #(
    parameter W = 6
) (
    input  wire         aclk,
    input  wire         aresetn,
    input  wire [W-1:0] divisor,
    output reg          tick
);
    reg [W-1:0] cnt_reg;
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= {W{1'b0}};
            tick    <= 1'b0;
        end else if (cnt_reg >= divisor - {{(W-1){1'b0}}, 1'b1}) begin
            cnt_reg <= {W{1'b0}};
            tick    <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
            tick    <= 1'b0;
        end
    end
endmodule // psm_clk_div

// [design/psm_ctrl.v]
// power saving mode controller with axi4-lite registers
`timescale 1ns/1ps
`include "psm_defs.vh"
module psm_ctrl #(
    parameter STAB_CYCLES = `PSM_STAB_CYCLES
) (
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // cpu core side
    input  wire        instr_valid,
    input  wire [7:0]  instr_opcode,
    input  wire        wait_for_interrupt_instr,
    input  wire        irq_pending,
    input  wire        irq_halt_wakeup,
    input  wire        timebase_irq,
    input  wire        irq_is_trap,
    input  wire [1:0]  irq_sw_prio,
    input  wire        irq_ack,
    input  wire        iret_pop,
    input  wire [1:0]  popped_prio,
    input  wire        watchdog_active,
    input  wire        ext_wake_pin,
    output reg  [1:0]  cc_prio,
    output reg         cc_push,
    output reg         core_clk_en,
    output reg         periph_clk_en,
    output reg         timebase_clk_en,
    output reg         osc_enable,
    output reg         cpu_release,
    output reg         watchdog_reset
);
    localparam ST_RUN    = 3'd0;
    localparam ST_WAIT   = 3'd1;
    localparam ST_AHALT  = 3'd2;
    localparam ST_HALT   = 3'd3;
    localparam ST_STAB   = 3'd4;
    localparam ST_RESET  = 3'd5;
    localparam CW        = 13;
    localparam [CW-1:0] STAB_LAST = STAB_CYCLES - 1;

    reg [2:0]    state_reg;
    reg [2:0]    misc_control_reg;
    reg          timebase_irq_enable;
    reg          watchdog_on_stop_option;
    reg [CW-1:0] stab_cnt_reg;
    reg          wake_irq_reg;
    reg          aw_got_reg;
    reg          w_got_reg;
    reg [7:0]    aw_addr_reg;
    reg [31:0]   w_data_reg;
    reg [3:0]    w_strb_reg;
    reg [5:0]    div_sel;
    wire         div_tick;
    wire         ext_wake;
    wire         slow_mode_enable = misc_control_reg[`PSM_SMS_BIT];
    wire [1:0]   slow_freq_select = misc_control_reg[`PSM_CP_LSB +: 2];
    wire         do_write;

    psm_sync u_wake_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       (ext_wake_pin),
        .q       (ext_wake)
    );

    always @* begin
        if (!slow_mode_enable) begin
            div_sel = `PSM_DIV_RUN;
        end else begin
            case (slow_freq_select)
                2'd0:    div_sel = `PSM_DIV_CP0;
                2'd1:    div_sel = `PSM_DIV_CP1;
                2'd2:    div_sel = `PSM_DIV_CP2;
                default: div_sel = `PSM_DIV_CP3;
            endcase
        end
    end

    psm_clk_div #(.W(6)) u_div (
        .aclk    (aclk),
        .aresetn (aresetn),
        .divisor (div_sel),
        .tick    (div_tick)
    );

    wire halt_instr = instr_valid && (instr_opcode == `PSM_HALT_OPCODE);
    wire wfi_instr  = instr_valid && wait_for_interrupt_instr;
    wire halt_wake  = irq_halt_wakeup || ext_wake;

    // mode state machine
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_reg      <= ST_RESET;
            stab_cnt_reg   <= {CW{1'b0}};
            wake_irq_reg   <= 1'b0;
            watchdog_reset <= 1'b0;
        end else begin
            watchdog_reset <= 1'b0;
            case (state_reg)
                ST_RESET: begin
                    // reset exit waits out the restart delay
                    state_reg    <= ST_STAB;
                    stab_cnt_reg <= {CW{1'b0}};
                end
                ST_RUN: begin
                    if (halt_instr) begin
                        if (timebase_irq_enable) begin
                            state_reg <= ST_AHALT;
                        end else if (watchdog_active && !watchdog_on_stop_option) begin
                            // option bit clear asks for reset instead of halt
                            watchdog_reset <= 1'b1;
                        end else begin
                            state_reg <= ST_HALT;
                        end
                    end else if (wfi_instr) begin
                        state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (irq_pending) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_AHALT: begin
                    if (timebase_irq || halt_wake) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_HALT: begin
                    if (halt_wake) begin
                        state_reg    <= ST_STAB;
                        stab_cnt_reg <= {CW{1'b0}};
                        wake_irq_reg <= 1'b1;
                    end
                end
                ST_STAB: begin
                    if (stab_cnt_reg == STAB_LAST) begin
                        state_reg    <= ST_RUN;
                        wake_irq_reg <= 1'b0;
                    end else begin
                        stab_cnt_reg <= stab_cnt_reg + {{(CW-1){1'b0}}, 1'b1};
                    end
                end
                default: state_reg <= ST_RUN;
            endcase
        end
    end

    // clock gating outputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            core_clk_en     <= 1'b0;
            periph_clk_en   <= 1'b0;
            timebase_clk_en <= 1'b0;
            osc_enable      <= 1'b1;
            cpu_release     <= 1'b0;
        end else begin
            // cpu gated in wait, peripherals stay
            core_clk_en     <= div_tick && (state_reg == ST_RUN);
            periph_clk_en   <= div_tick && (state_reg == ST_RUN || state_reg == ST_WAIT);
            timebase_clk_en <= div_tick && (state_reg != ST_HALT) && (state_reg != ST_STAB);
            osc_enable      <= (state_reg != ST_HALT) || halt_wake;
            cpu_release     <= (state_reg == ST_RUN);
        end
    end

    // condition code priority bits
    always @(posedge aclk) begin
        if (!aresetn) begin
            cc_prio <= `PSM_PRIO_NONE;
            cc_push <= 1'b0;
        end else begin
            cc_push <= 1'b0;
            if (state_reg == ST_RUN && (halt_instr || wfi_instr)) begin
                cc_prio <= `PSM_PRIO_LEVEL0;
            end else if (irq_ack && state_reg == ST_RUN) begin
                cc_push <= 1'b1;
                cc_prio <= irq_is_trap ? `PSM_PRIO_NONE : irq_sw_prio;
            end else if (iret_pop) begin
                cc_prio <= popped_prio;
            end
        end
    end

    // axi4-lite write path
    assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_got_reg && !s_axi_bvalid;
    assign do_write      = aw_got_reg && w_got_reg && !s_axi_bvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg              <= 1'b0;
            w_got_reg               <= 1'b0;
            aw_addr_reg             <= 8'h00;
            w_data_reg              <= 32'h00000000;
            w_strb_reg              <= 4'h0;
            s_axi_bvalid            <= 1'b0;
            s_axi_bresp             <= 2'h0;
            misc_control_reg        <= `PSM_MISC_RESET;
            timebase_irq_enable     <= 1'b0;
            watchdog_on_stop_option <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg  <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg  <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_got_reg   <= 1'b0;
                w_got_reg    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= 2'h0;
                case (aw_addr_reg)
                    `PSM_ADDR_MISC_CTRL:
                        if (w_strb_reg[0]) misc_control_reg <= w_data_reg[2:0];
                    `PSM_ADDR_CLK_STATUS:
                        if (w_strb_reg[0]) timebase_irq_enable <= w_data_reg[`PSM_OIE_BIT];
                    `PSM_ADDR_OPTION:
                        if (w_strb_reg[0]) watchdog_on_stop_option <= w_data_reg[`PSM_WDG_STOP_BIT];
                    `PSM_ADDR_MODE_STAT: s_axi_bresp <= 2'h0;
                    default: s_axi_bresp <= 2'h2;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // axi4-lite read path
    assign s_axi_arready = !s_axi_rvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'h0;
            case (s_axi_araddr)
                `PSM_ADDR_MISC_CTRL:  s_axi_rdata <= {29'h0, misc_control_reg};
                `PSM_ADDR_CLK_STATUS: s_axi_rdata <= {31'h0, timebase_irq_enable};
                `PSM_ADDR_MODE_STAT:  s_axi_rdata <= {24'h0, wake_irq_reg, state_reg,
                                                      2'h0, cc_prio};
                `PSM_ADDR_OPTION:     s_axi_rdata <= {31'h0, watchdog_on_stop_option};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // psm_ctrl

// [design/psm_defs.vh]
// constants for the power saving mode controller
`ifndef PSM_DEFS_VH
`define PSM_DEFS_VH
// axi4-lite register byte addresses
`define PSM_ADDR_MISC_CTRL   8'h00
`define PSM_ADDR_CLK_STATUS  8'h04
`define PSM_ADDR_MODE_STAT   8'h08
`define PSM_ADDR_OPTION      8'h0c
// misc_control_reg fields
`define PSM_SMS_BIT          2
`define PSM_CP_LSB           0
`define PSM_MISC_RESET       3'h0
// main_clock_status_reg fields
`define PSM_OIE_BIT          0
// option register fields
`define PSM_WDG_STOP_BIT     0
// divisors
`define PSM_DIV_RUN          6'h02
`define PSM_DIV_CP0          6'h04
`define PSM_DIV_CP1          6'h08
`define PSM_DIV_CP2          6'h10
`define PSM_DIV_CP3          6'h20
// priority bits
`define PSM_PRIO_LEVEL0      2'h2
`define PSM_PRIO_NONE        2'h3
// halt opcode
`define PSM_HALT_OPCODE      8'h8e
// stabilisation delay, oscillator cycles
`define PSM_STAB_CYCLES      4096
`endif

// [design/psm_sync.v]
// two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module psm_sync (
    input  wire aclk,
    input  wire aresetn,
    input  wire d,
    output reg  q
);
    reg meta_reg;
    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= 1'b0;
            q        <= 1'b0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule // psm_sync

// [verif/power_saving_mode_control_tb_top.sv]
// self-checking bench for the power saving mode controller
`timescale 1ns/1ps
module power_saving_mode_control_tb_top;
    localparam STAB = 16;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, instr_valid, wait_for_interrupt_instr, irq_pending;
    logic        irq_halt_wakeup, timebase_irq, irq_is_trap, irq_ack, iret_pop;
    logic        watchdog_active, ext_wake_pin, cc_push, core_clk_en, periph_clk_en;
    logic        timebase_clk_en, osc_enable, cpu_release, watchdog_reset;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, instr_opcode;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, irq_sw_prio, popped_prio, cc_prio, rsp;
    int          n_fail, checks, n, nc, np, nt, i, k;
    logic        dog_seen = 1'b0;
    int          push_n = 0;
    // rows: {misc_control_reg value, expected tick period}
    logic [10:0] rows [0:4] = '{11'h002, 11'h404, 11'h508, 11'h610, 11'h720};

    psm_ctrl #(.STAB_CYCLES(STAB)) dut (.*);
    psm_core_model model (.*);

    always #2.5 aclk = ~aclk;
    always @(posedge aclk) if (watchdog_reset === 1'b1) dog_seen <= 1'b1;
    always @(posedge aclk) if (cc_push === 1'b1) push_n <= push_n + 1;

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic tmo(input int c);
        if (c >= 200) begin
            n_fail++;
            $display("ERROR handshake expected answer seen none");
            close_out;
        end
    endtask
    // handshakes judged on settled values, acted on at the next rising edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic hs_aw, hs_w, hs_b;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (k = 0; k < 200; k++) begin
            @(negedge aclk);
            hs_aw = s_axi_awvalid && s_axi_awready;
            hs_w = s_axi_wvalid && s_axi_wready;
            hs_b = s_axi_bvalid;
            @(posedge aclk);
            if (hs_aw) s_axi_awvalid <= 1'b0;
            if (hs_w) s_axi_wvalid <= 1'b0;
            if (hs_b) break;
        end
        s_axi_bready <= 1'b0;
        tmo(k);
    endtask
    task automatic axi_rd(input logic [7:0] a);
        logic hs_ar, hs_r;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (k = 0; k < 200; k++) begin
            @(negedge aclk);
            hs_ar = s_axi_arvalid && s_axi_arready;
            hs_r = s_axi_rvalid;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge aclk);
            if (hs_ar) s_axi_arvalid <= 1'b0;
            if (hs_r) break;
        end
        s_axi_rready <= 1'b0;
        tmo(k);
    endtask
    task automatic ticks(input int c);
        nc = 0;
        np = 0;
        nt = 0;
        repeat (c) begin
            @(posedge aclk);
            @(negedge aclk);
            nc += core_clk_en;
            np += periph_clk_en;
            nt += timebase_clk_en;
        end
        @(posedge aclk);
    endtask
    // cycles between two peripheral ticks
    task automatic period;
        for (k = 0; k < 200; k++) begin
            @(negedge aclk);
            if (periph_clk_en) break;
        end
        for (n = 1; n < 200; n++) begin
            @(negedge aclk);
            if (periph_clk_en) break;
        end
        @(posedge aclk);
    endtask
    task automatic rel;
        for (n = 0; n < 300; n++) begin
            @(negedge aclk);
            if (cpu_release) break;
        end
        @(posedge aclk);
    endtask
    task automatic op(input logic [7:0] c, input logic w);
        @(posedge aclk);
        instr_opcode <= c;
        {instr_valid, wait_for_interrupt_instr} <= {1'b1, w};
        @(posedge aclk);
        instr_valid <= 1'b0;
    endtask

    initial begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 6'h00;
        {s_axi_rready, instr_valid, wait_for_interrupt_instr, irq_pending} = 4'h0;
        {irq_halt_wakeup, timebase_irq, watchdog_active, ext_wake_pin} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, instr_opcode, s_axi_wdata} = 56'h0;
        s_axi_wstrb = 4'h1;
        repeat (20) @(posedge aclk);
        check("cc_prio in reset", cc_prio, 2'h3);
        check("release in reset", cpu_release, 1'b0);
        aresetn <= 1'b1;
        rel;
        check("reset delay", n >= STAB && n <= STAB + 6, 1'b1);
        axi_rd(8'h08);
        check("mode after reset", rd[6:0], 7'h03);
        axi_rd(8'h00);
        check("misc after reset", rd, 32'h0);
        for (i = 0; i < 5; i++) begin
            axi_wr(8'h00, rows[i][10:8]);
            repeat (2) period;
            check("divisor", n, rows[i][7:0]);
        end
        axi_wr(8'h00, 32'h4);
        op(8'h8f, 1'b1);
        ticks(40);
        check("wait core ticks", nc, 0);
        check("wait cc_prio", cc_prio, 2'h2);
        repeat (2) period;
        check("slow wait period", n, 4);
        axi_rd(8'h08);
        check("wait state", rd[6:4], 3'h1);
        irq_pending <= 1'b1;
        rel;
        check("wait wake", n < 8, 1'b1);
        repeat (12) @(posedge aclk);
        check("cc push", push_n != 0, 1'b1);
        irq_pending <= 1'b0;
        axi_wr(8'h00, 32'h0);
        axi_wr(8'h04, 32'h0);
        op(8'h8e, 1'b0);
        ticks(4);
        ticks(20);
        check("halt osc", osc_enable, 1'b0);
        check("halt ticks", nc + np + nt, 0);
        irq_halt_wakeup <= 1'b1;
        rel;
        check("halt delay", n >= STAB && n <= STAB + 6, 1'b1);
        irq_halt_wakeup <= 1'b0;
        axi_wr(8'h0c, 32'h0);
        axi_wr(8'h04, 32'h1);
        watchdog_active <= 1'b1;
        op(8'h8e, 1'b0);
        ticks(4);
        ticks(40);
        check("active halt ticks", {nc != 0, np != 0, nt != 0}, 3'h1);
        check("active halt osc", osc_enable, 1'b1);
        {timebase_irq, irq_pending} <= 2'h3;
        rel;
        check("active halt exit", n < STAB, 1'b1);
        check("active halt dog", dog_seen, 1'b0);
        repeat (12) @(posedge aclk);
        {timebase_irq, irq_pending} <= 2'h0;
        axi_wr(8'h04, 32'h0);
        op(8'h8e, 1'b0);
        ticks(8);
        check("dog reset", dog_seen, 1'b1);
        check("dog no halt", osc_enable, 1'b1);
        watchdog_active <= 1'b0;
        axi_rd(8'h10);
        check("unmapped resp", rsp, 2'h2);
        close_out;
    end
endmodule // power_saving_mode_control_tb_top

// [verif/psm_core_model.sv]
// core and interrupt controller stand-in for the power mode controller
`timescale 1ns/1ps
module psm_core_model #(
    parameter logic [1:0] PRIO = 2'h1
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        cpu_release,
    input  wire        irq_pending,
    input  wire  [1:0] cc_prio,
    output logic       irq_ack,
    output logic       irq_is_trap,
    output logic       iret_pop,
    output logic [1:0] irq_sw_prio,
    output logic [1:0] popped_prio
);
    logic [2:0] cnt_reg;
    logic [1:0] save_reg;
    logic       busy_reg;
    logic       trap_reg;
    // fetch, every second one a trap
    always @(posedge aclk) begin
        irq_ack <= 1'b0;
        iret_pop <= 1'b0;
        // unqualified fields toggle so stale values never look valid
        irq_sw_prio <= ~irq_sw_prio;
        popped_prio <= ~popped_prio;
        irq_is_trap <= ~irq_is_trap;
        if (!aresetn) begin
            {busy_reg, trap_reg, cnt_reg} <= 5'h00;
            {irq_sw_prio, popped_prio, irq_is_trap} <= 5'h00;
        end else if (!busy_reg) begin
            if (irq_pending && cpu_release) begin
                {irq_ack, busy_reg, cnt_reg} <= 5'h18;
                irq_is_trap <= trap_reg;
                trap_reg <= ~trap_reg;
                irq_sw_prio <= PRIO;
                save_reg <= cc_prio;
            end
        end else if (cnt_reg != 3'h7) begin
            cnt_reg <= cnt_reg + 3'h1;
            if (cnt_reg == 3'h2) begin
                iret_pop <= 1'b1;
                popped_prio <= save_reg;
            end
        end else if (!irq_pending) begin
            busy_reg <= 1'b0;
        end
    end
endmodule // psm_core_model

// [verif/psm_ctrl_props.sv]
// port assertions for the power saving mode controller
`timescale 1ns/1ps
module psm_ctrl_props #(
    parameter STAB_CYCLES = 4096
) (
    input wire       aclk,
    input wire       aresetn,
    input wire       instr_valid,
    input wire [7:0] instr_opcode,
    input wire       wait_for_interrupt_instr,
    input wire       irq_is_trap,
    input wire [1:0] irq_sw_prio,
    input wire       irq_ack,
    input wire       iret_pop,
    input wire [1:0] popped_prio,
    input wire       watchdog_active,
    input wire [1:0] cc_prio,
    input wire       core_clk_en,
    input wire       periph_clk_en,
    input wire       timebase_clk_en,
    input wire       osc_enable,
    input wire       cpu_release,
    input wire       watchdog_reset
);
    logic        from_halt_reg;
    int unsigned since_reg;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // time since oscillator restart, only a halt exit is judged
    always @(posedge aclk) begin
        if (!aresetn || $rose(cpu_release))
            from_halt_reg <= 1'b0;
        else if ($fell(osc_enable))
            from_halt_reg <= 1'b1;
        if (!aresetn || $rose(osc_enable))
            since_reg <= 0;
        else if (since_reg < 60000)
            since_reg <= since_reg + 1;
    end
    prio_wait_a: assert property (
        instr_valid && wait_for_interrupt_instr && cpu_release |=> cc_prio == 2'h2)
        else $error("wait entry kept old priority");
    prio_halt_a: assert property (
        instr_valid && instr_opcode == 8'h8e && !wait_for_interrupt_instr && cpu_release
        && !watchdog_active |=> cc_prio == 2'h2) else $error("halt entry kept old priority");
    osc_gate_a: assert property (
        !osc_enable && $past(osc_enable) == 1'b0 |-> !(core_clk_en || periph_clk_en
        || timebase_clk_en)) else $error("clock tick with oscillator off");
    stab_wait_a: assert property (
        $rose(cpu_release) && from_halt_reg |-> since_reg >= STAB_CYCLES - 1)
        else $error("cpu released before stabilisation count");
    dog_cause_a: assert property (
        watchdog_reset |-> $past(instr_valid) && $past(instr_opcode) == 8'h8e
        && $past(watchdog_active)) else $error("watchdog reset without halt");
    push_prio_a: assert property (
        irq_ack && !irq_is_trap |=> cc_prio == $past(irq_sw_prio))
        else $error("routine priority not loaded");
    trap_prio_a: assert property (
        irq_ack && irq_is_trap |=> cc_prio == 2'h3) else $error("trap left priority open");
    pop_prio_a: assert property (
        iret_pop |=> cc_prio == $past(popped_prio)) else $error("pop lost priority");
endmodule // psm_ctrl_props

bind psm_ctrl psm_ctrl_props #(.STAB_CYCLES(STAB_CYCLES)) props (.*);
